// ===== src/swpb_pkg.sv
package swpb_pkg;

   // ----------------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int BYTE_W = 8;
   localparam logic [11:0] WORD_MASK = 12'hFFC;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [11:0] OFF_SOFT_RESET = 12'h048;
   localparam logic [11:0] OFF_EXT_DDR = 12'h060;
   localparam logic [11:0] OFF_BRIDGE = 12'h098;
   localparam logic [11:0] OFF_PLAIN_RW = 12'h0B0;
   localparam logic [11:0] OFF_HW_STATUS = 12'h140;
   localparam logic [11:0] OFF_HIDDEN = 12'h144;
   localparam logic [11:0] OFF_PRELOAD_STATUS = 12'h184;
   localparam logic [11:0] OFF_STICKY = 12'h190;
   localparam logic [11:0] OFF_CLEAR_PULSE = 12'h1A4;

   // ----------------------------------------------------------------------
   // Field layouts and reset values
   // ----------------------------------------------------------------------
   localparam int SOFT_RESET_W = 16;
   localparam int STICKY_W = 8;
   localparam int CLEAR_W = 2;
   localparam int FIELD_W = 8;
   localparam int FIELD_N = 4;
   localparam logic [31:0] PLAIN_RW_RESET = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Responses and states
   // ----------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SWPB_WS_COLLECT = 2'b01,
      SWPB_WS_RESP = 2'b10
   } swpb_wstate_type;

endpackage : swpb_pkg

// ===== src/swpb_merge_if.sv
`timescale 1ns/1ps
`default_nettype none

interface swpb_merge_if;
   logic [31:0] old_val;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [31:0] unlock;
   logic [31:0] merged;

   modport user (
      output old_val,
      output wr_data,
      output wr_strb,
      output unlock,
      input merged
   );

   modport merger (
      input old_val,
      input wr_data,
      input wr_strb,
      input unlock,
      output merged
   );
endinterface : swpb_merge_if

`default_nettype wire

// ===== src/swpb_merge.sv
`timescale 1ns/1ps
`default_nettype none

module swpb_merge (
   swpb_merge_if.merger mp
);

   logic [31:0] byte_mask;
   logic [31:0] take;

   always_comb begin
      for (int i = 0; i < swpb_pkg::STRB_W; i++) begin
         byte_mask[i*swpb_pkg::BYTE_W +: swpb_pkg::BYTE_W] =
            {swpb_pkg::BYTE_W{mp.wr_strb[i]}};
      end
   end

   // [R20] Merge unlocked bits.
   assign take = byte_mask & mp.unlock;
   assign mp.merged = (mp.old_val & ~take) | (mp.wr_data & take);

endmodule : swpb_merge

`default_nettype wire

// ===== src/swpb_bank.sv
// Summary of operation
// [R1] All bus masters read and write registers.
// [R2] Configuration loads before any access served.
// [R3] Register lock keeps whole register unchanged.
// [R4] Field lock keeps that field unchanged.
// [R5] Bit lock keeps that single bit.
// [R6] Lock bits come only from configuration.
// [R7] Preloaded registers reload at power-on; soft reset, status and hidden also at system reset.
// [R8] Plain register resets to fixed value.
// [R9] Read-only register shows live hardware state.
// [R10] Preloaded status is read-only, reloaded.
// [R11] Hidden register: no read, no write.
// [R12] Writing one pulses a clear.
// [R13] Sticky bit sets, cleared by one.
// [R14] Lock value one means writable.
// [R15] Soft reset register: bit locks, system reset.
// [R16] DDR config reset only at power-on.
// [R17] Bridge config fields, clock-controller reset.
// [R18] Block reset from system or soft request.
// [R19] Blocked writes still answer OKAY.
// [R20] Mixed writes merge unlocked bits only.
`timescale 1ns/1ps
`default_nettype none

module swpb_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic power_on_reset_low,
   input wire logic system_reset_low,
   input wire logic clock_ctrl_reset_low,
   input wire logic [15:0] cfg_soft_reset_init,
   input wire logic [15:0] cfg_soft_reset_unlock,
   input wire logic [31:0] cfg_ext_ddr_init,
   input wire logic cfg_ext_ddr_unlock,
   input wire logic [31:0] cfg_bridge_init,
   input wire logic [3:0] cfg_bridge_field_unlock,
   input wire logic [31:0] cfg_status_init,
   input wire logic [31:0] cfg_hidden_init,
   input wire logic [31:0] hw_status,
   input wire logic [7:0] hw_event,
   output logic [15:0] peripheral_soft_reset_ctrl,
   output logic [15:0] periph_block_reset_low,
   output logic [31:0] ext_ddr_config,
   output logic [31:0] bridge_align_clock_cfg1,
   output logic [31:0] plain_rw_ctrl,
   output logic [31:0] hidden_ctrl,
   output logic [1:0] clear_pulse
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      swpb_pkg::swpb_wstate_type wst;
      logic aw_got;
      logic w_got;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [11:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [15:0] soft_rst;
      logic [15:0] blk_rst_n;
      logic [31:0] ext_ddr;
      logic [31:0] bridge;
      logic [31:0] plain_rw;
      logic [31:0] pre_stat;
      logic [31:0] hidden;
      logic [7:0] sticky;
      logic [1:0] clr_pulse;
   } swpb_state_type;

   swpb_state_type s_r;
   swpb_state_type s_nxt;

   logic por;
   logic sysr;
   logic ccr;
   logic wr_exec;
   logic [11:0] wa;
   logic [11:0] ra;
   logic ar_take;
   logic [31:0] bridge_mask;
   logic [7:0] sticky_clr;

   // Power-on covers the bus reset too, so every load happens together.
   assign por = !aresetn || !power_on_reset_low;
   assign sysr = por || !system_reset_low;
   assign ccr = por || !clock_ctrl_reset_low;
   assign wr_exec = (s_r.wst == swpb_pkg::SWPB_WS_COLLECT) &&
                    s_r.aw_got && s_r.w_got;
   assign wa = s_r.waddr & swpb_pkg::WORD_MASK;
   assign ra = s_axi_araddr & swpb_pkg::WORD_MASK;
   assign ar_take = s_axi_arvalid && s_r.arready;

   // ----------------------------------------------------------------------
   // Write merging
   // ----------------------------------------------------------------------
   swpb_merge_if m_soft ();
   swpb_merge_if m_ddr ();
   swpb_merge_if m_br ();
   swpb_merge_if m_rw ();

   always_comb begin
      for (int i = 0; i < swpb_pkg::FIELD_N; i++) begin
         // [R4] One lock per field.
         bridge_mask[i*swpb_pkg::FIELD_W +: swpb_pkg::FIELD_W] =
            {swpb_pkg::FIELD_W{cfg_bridge_field_unlock[i]}};
      end
   end

   // [R6] Locks are inputs only; no bus path reaches them.
   // [R14] A lock input at one leaves the bits writable.
   assign m_soft.old_val = swpb_pkg::DATA_W'(s_r.soft_rst);
   assign m_soft.wr_data = s_r.wdata;
   assign m_soft.wr_strb = s_r.wstrb;
   // [R5] Per-bit locks.
   assign m_soft.unlock = swpb_pkg::DATA_W'(cfg_soft_reset_unlock);
   assign m_ddr.old_val = s_r.ext_ddr;
   assign m_ddr.wr_data = s_r.wdata;
   assign m_ddr.wr_strb = s_r.wstrb;
   // [R3] Whole-register lock.
   assign m_ddr.unlock = {swpb_pkg::DATA_W{cfg_ext_ddr_unlock}};
   assign m_br.old_val = s_r.bridge;
   assign m_br.wr_data = s_r.wdata;
   assign m_br.wr_strb = s_r.wstrb;
   assign m_br.unlock = bridge_mask;
   assign m_rw.old_val = s_r.plain_rw;
   assign m_rw.wr_data = s_r.wdata;
   assign m_rw.wr_strb = s_r.wstrb;
   assign m_rw.unlock = ~swpb_pkg::ZERO_WORD;

   swpb_merge u_m_soft (.mp(m_soft));
   swpb_merge u_m_ddr (.mp(m_ddr));
   swpb_merge u_m_br (.mp(m_br));
   swpb_merge u_m_rw (.mp(m_rw));

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.clr_pulse = '0;
      sticky_clr = '0;
      case (s_r.wst)
         swpb_pkg::SWPB_WS_COLLECT: begin
            if (s_axi_awvalid && s_r.awready) begin
               s_nxt.aw_got = 1'b1;
               s_nxt.waddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_r.wready) begin
               s_nxt.w_got = 1'b1;
               s_nxt.wdata = s_axi_wdata;
               s_nxt.wstrb = s_axi_wstrb;
            end
            if (wr_exec) begin
               s_nxt.aw_got = 1'b0;
               s_nxt.w_got = 1'b0;
               s_nxt.bvalid = 1'b1;
               s_nxt.wst = swpb_pkg::SWPB_WS_RESP;
               // [R19] Locked, read-only and hidden all answer OKAY.
               s_nxt.bresp = swpb_pkg::RESP_OKAY;
               // [R1] Writes reach each writable register.
               case (wa)
                  swpb_pkg::OFF_SOFT_RESET:
                     s_nxt.soft_rst = m_soft.merged[15:0];
                  swpb_pkg::OFF_EXT_DDR: s_nxt.ext_ddr = m_ddr.merged;
                  swpb_pkg::OFF_BRIDGE: s_nxt.bridge = m_br.merged;
                  swpb_pkg::OFF_PLAIN_RW: s_nxt.plain_rw = m_rw.merged;
                  swpb_pkg::OFF_CLEAR_PULSE: begin
                     // [R12] Ones become a one-cycle clear.
                     s_nxt.clr_pulse = s_r.wdata[1:0] &
                                       {swpb_pkg::CLEAR_W{s_r.wstrb[0]}};
                  end
                  swpb_pkg::OFF_STICKY: begin
                     sticky_clr = s_r.wdata[7:0] &
                                  {swpb_pkg::STICKY_W{s_r.wstrb[0]}};
                  end
                  swpb_pkg::OFF_HW_STATUS, swpb_pkg::OFF_HIDDEN,
                  swpb_pkg::OFF_PRELOAD_STATUS: begin
                  end
                  default: s_nxt.bresp = swpb_pkg::RESP_SLVERR;
               endcase
            end
         end
         swpb_pkg::SWPB_WS_RESP: begin
            if (s_axi_bready) begin
               s_nxt.bvalid = 1'b0;
               s_nxt.wst = swpb_pkg::SWPB_WS_COLLECT;
            end
         end
         default: begin
            s_nxt.wst = swpb_pkg::SWPB_WS_COLLECT;
            s_nxt.bvalid = 1'b0;
         end
      endcase

      // [R13] Set wins over a clear in the same cycle.
      s_nxt.sticky = (s_r.sticky & ~sticky_clr) | hw_event;

      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (ar_take) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = swpb_pkg::RESP_OKAY;
         case (ra)
            swpb_pkg::OFF_SOFT_RESET:
               s_nxt.rdata = swpb_pkg::DATA_W'(s_r.soft_rst);
            swpb_pkg::OFF_EXT_DDR: s_nxt.rdata = s_r.ext_ddr;
            swpb_pkg::OFF_BRIDGE: s_nxt.rdata = s_r.bridge;
            swpb_pkg::OFF_PLAIN_RW: s_nxt.rdata = s_r.plain_rw;
            // [R9] Live hardware value.
            swpb_pkg::OFF_HW_STATUS: s_nxt.rdata = hw_status;
            swpb_pkg::OFF_PRELOAD_STATUS: s_nxt.rdata = s_r.pre_stat;
            swpb_pkg::OFF_STICKY:
               s_nxt.rdata = swpb_pkg::DATA_W'(s_r.sticky);
            // [R11] Hidden contents never reach the bus; reads return zero.
            swpb_pkg::OFF_HIDDEN, swpb_pkg::OFF_CLEAR_PULSE:
               s_nxt.rdata = swpb_pkg::ZERO_WORD;
            default: begin
               s_nxt.rdata = swpb_pkg::ZERO_WORD;
               s_nxt.rresp = swpb_pkg::RESP_SLVERR;
            end
         endcase
      end

      // [R7] System reset reloads preloaded registers except DDR and bridge config.
      if (sysr) begin
         // [R15] Soft reset bits reload on system reset.
         s_nxt.soft_rst = cfg_soft_reset_init;
         // [R10] Status preload.
         s_nxt.pre_stat = cfg_status_init;
         s_nxt.hidden = cfg_hidden_init;
         // [R8] Fixed reset value, no preload.
         s_nxt.plain_rw = swpb_pkg::PLAIN_RW_RESET;
         s_nxt.sticky = '0;
         s_nxt.clr_pulse = '0;
      end
      // [R16] Power-on only.
      if (por) begin
         s_nxt.ext_ddr = cfg_ext_ddr_init;
      end
      // [R17] Clock-controller reset.
      if (ccr) begin
         s_nxt.bridge = cfg_bridge_init;
      end
      if (por) begin
         s_nxt.wst = swpb_pkg::SWPB_WS_COLLECT;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b0;
         s_nxt.bresp = swpb_pkg::RESP_OKAY;
         s_nxt.rvalid = 1'b0;
         s_nxt.rresp = swpb_pkg::RESP_OKAY;
         s_nxt.rdata = swpb_pkg::ZERO_WORD;
         s_nxt.waddr = '0;
         s_nxt.wdata = swpb_pkg::ZERO_WORD;
         s_nxt.wstrb = '0;
      end

      // [R2] Bus stays stalled while configuration loads.
      s_nxt.awready = (s_nxt.wst == swpb_pkg::SWPB_WS_COLLECT) &&
                      !s_nxt.aw_got && !por;
      s_nxt.wready = (s_nxt.wst == swpb_pkg::SWPB_WS_COLLECT) &&
                     !s_nxt.w_got && !por;
      s_nxt.arready = !s_nxt.rvalid && !por;

      // [R18] Block reset from system reset or soft request.
      s_nxt.blk_rst_n = ~(s_r.soft_rst | {swpb_pkg::SOFT_RESET_W{sysr}});
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rdata = s_r.rdata;
   assign peripheral_soft_reset_ctrl = s_r.soft_rst;
   assign periph_block_reset_low = s_r.blk_rst_n;
   assign ext_ddr_config = s_r.ext_ddr;
   assign bridge_align_clock_cfg1 = s_r.bridge;
   assign plain_rw_ctrl = s_r.plain_rw;
   assign hidden_ctrl = s_r.hidden;
   assign clear_pulse = s_r.clr_pulse;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_wr_taken;
      wr_exec;
   endsequence

   sequence s_resp_held;
      s_r.bvalid && (s_r.wst == swpb_pkg::SWPB_WS_RESP);
   endsequence

   property p_wr_answer;
      s_wr_taken and !por |=> s_resp_held;
   endproperty
   a_wr_answer: assert property (p_wr_answer) // [R19]
      else $error("write not answered one cycle after capture");

   property p_load_stall;
      por |=> !s_r.awready && !s_r.wready && !s_r.arready;
   endproperty
   a_load_stall: assert property (p_load_stall) // [R2]
      else $error("bus ready while configuration loads");

   property p_reg_lock;
      wr_exec && (wa == swpb_pkg::OFF_EXT_DDR) && !cfg_ext_ddr_unlock &&
      !por |=> s_r.ext_ddr == $past(s_r.ext_ddr);
   endproperty
   a_reg_lock: assert property (p_reg_lock) // [R3]
      else $error("locked DDR config changed by write");

   property p_field_lock;
      wr_exec && (wa == swpb_pkg::OFF_BRIDGE) && !ccr |=>
      ((s_r.bridge ^ $past(s_r.bridge)) & ~$past(bridge_mask)) == '0;
   endproperty
   a_field_lock: assert property (p_field_lock) // [R4]
      else $error("locked bridge field changed");

   property p_bit_lock;
      wr_exec && (wa == swpb_pkg::OFF_SOFT_RESET) && !sysr |=>
      ((s_r.soft_rst ^ $past(s_r.soft_rst)) &
       ~$past(cfg_soft_reset_unlock)) == '0;
   endproperty
   a_bit_lock: assert property (p_bit_lock) // [R5]
      else $error("locked soft reset bit changed");

   sequence s_pulse_shape;
      (s_r.clr_pulse == $past(s_r.wdata[1:0])) ##1 (s_r.clr_pulse == '0);
   endsequence

   property p_clear_pulse;
      wr_exec && (wa == swpb_pkg::OFF_CLEAR_PULSE) && s_r.wstrb[0] &&
      !sysr |=> s_pulse_shape;
   endproperty
   a_clear_pulse: assert property (p_clear_pulse) // [R12]
      else $error("clear pulse wrong value or length");

   property p_sticky_set;
      (|hw_event) && !sysr |=>
      (s_r.sticky & $past(hw_event)) == $past(hw_event);
   endproperty
   a_sticky_set: assert property (p_sticky_set) // [R13]
      else $error("sticky bit missed a hardware event");

   property p_block_reset;
      !system_reset_low |=> s_r.blk_rst_n == '0;
   endproperty
   a_block_reset: assert property (p_block_reset) // [R18]
      else $error("block reset not asserted under system reset");

   property p_ddr_keeps;
      !system_reset_low && !por && !wr_exec |=>
      s_r.ext_ddr == $past(s_r.ext_ddr);
   endproperty
   a_ddr_keeps: assert property (p_ddr_keeps) // [R16]
      else $error("DDR config disturbed by system reset");

   property p_hidden_read;
      ar_take && (ra == swpb_pkg::OFF_HIDDEN) && !por |=>
      s_r.rvalid && (s_r.rdata == swpb_pkg::ZERO_WORD);
   endproperty
   a_hidden_read: assert property (p_hidden_read) // [R11]
      else $error("hidden register contents leaked on read");

endmodule : swpb_bank

`default_nettype wire

// ===== verif/swpb_axi_master.sv
`timescale 1ns/1ps
`default_nettype none

module swpb_axi_master (
   input wire logic aclk,
   output logic [11:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   output logic bready,
   output logic [11:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   output logic rready,
   output logic hung
);
   // ---------------------------------------------------------------
   // Bus master transfers
   // ---------------------------------------------------------------
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, hung} = '0;
   end

   task automatic write(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 200);
      bready <= 1'b0;
      // A slave that never answers ends the run instead of hanging it.
      if (n >= 200) hung <= 1'b1;
   endtask : write

   task automatic read(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready) && n < 200);
      rready <= 1'b0;
      if (n >= 200) hung <= 1'b1;
   endtask : read
endmodule : swpb_axi_master

`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, hung;
   logic arvalid, arready, rvalid, rready, cfg_ext_ddr_unlock;
   logic [31:0] wdata, rdata, hw_status, cfg_ext_ddr_init;
   logic [3:0] wstrb, cfg_bridge_field_unlock;
   logic [1:0] bresp, rresp, clear_pulse;
   logic power_on_reset_low, system_reset_low, clock_ctrl_reset_low;
   logic [15:0] cfg_soft_reset_init, cfg_soft_reset_unlock, e_soft;
   logic [15:0] peripheral_soft_reset_ctrl, periph_block_reset_low;
   logic [31:0] cfg_bridge_init, cfg_status_init, cfg_hidden_init;
   logic [31:0] ext_ddr_config, bridge_align_clock_cfg1, plain_rw_ctrl;
   logic [31:0] hidden_ctrl, e_ddr, e_brg, e_plain, m, u, pc0, pc1;
   logic [7:0] hw_event, e_stk;
   logic [33:0] exp_r[$];
   logic [1:0] exp_b[$];
   int n_mismatch = 0;
   int comparisons = 0;
   int seed = 29072;
   localparam logic [1:0] OK = swpb_pkg::RESP_OKAY;

   always #25 aclk = ~aclk;

   swpb_bank u_swpb_bank (.aclk, .aresetn, .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .power_on_reset_low, .system_reset_low,
      .clock_ctrl_reset_low, .cfg_soft_reset_init, .cfg_soft_reset_unlock,
      .cfg_ext_ddr_init, .cfg_ext_ddr_unlock, .cfg_bridge_init,
      .cfg_bridge_field_unlock, .cfg_status_init, .cfg_hidden_init,
      .hw_status, .hw_event, .peripheral_soft_reset_ctrl,
      .periph_block_reset_low, .ext_ddr_config, .bridge_align_clock_cfg1,
      .plain_rw_ctrl, .hidden_ctrl, .clear_pulse);

   swpb_axi_master u_swpb_axi_master (.aclk, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rvalid, .rready, .hung);

   // ---------------------------------------------------------------
   // Checking and verdict
   // ---------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   always @(posedge aclk) begin
      if (rvalid && rready) begin
         if (exp_r.size() == 0) check(34'h0, 34'h1);
         else check({rresp, rdata}, exp_r.pop_front());
      end
      if (bvalid && bready) begin
         if (exp_b.size() == 0) check(34'h0, 34'h1);
         else check({32'h0000_0000, bresp}, 34'(exp_b.pop_front()));
      end
      if (aresetn) begin
         pc0 <= pc0 + {31'h0, clear_pulse[0]};
         pc1 <= pc1 + {31'h0, clear_pulse[1]};
      end
   end

   always @(posedge hung) begin
      n_mismatch++;
      print_verdict();
   end

   task automatic rd(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
      exp_r.push_back({r, d});
      u_swpb_axi_master.read(a);
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] r);
      exp_b.push_back(r);
      u_swpb_axi_master.write(a, d, s);
   endtask : wr

   task automatic rd_all;
      rd(swpb_pkg::OFF_SOFT_RESET, {16'h0000, e_soft}, OK);
      rd(swpb_pkg::OFF_EXT_DDR, e_ddr, OK);
      rd(swpb_pkg::OFF_BRIDGE, e_brg, OK);
      rd(swpb_pkg::OFF_PLAIN_RW, e_plain, OK);
      rd(swpb_pkg::OFF_HW_STATUS, hw_status, OK);
      rd(swpb_pkg::OFF_HIDDEN, 32'h0000_0000, OK);
      rd(swpb_pkg::OFF_PRELOAD_STATUS, cfg_status_init, OK);
      rd(swpb_pkg::OFF_STICKY, {24'h00_0000, e_stk}, OK);
      rd(swpb_pkg::OFF_CLEAR_PULSE, 32'h0000_0000, OK);
      rd(12'h004, 32'h0000_0000, swpb_pkg::RESP_SLVERR);
      @(negedge aclk);
      check({18'h0, peripheral_soft_reset_ctrl}, {18'h0, e_soft});
      check({18'h0, periph_block_reset_low}, {18'h0, ~e_soft});
      check({2'h0, ext_ddr_config}, {2'h0, e_ddr});
      check({2'h0, bridge_align_clock_cfg1}, {2'h0, e_brg});
      check({2'h0, plain_rw_ctrl}, {2'h0, e_plain});
      check({2'h0, hidden_ctrl}, {2'h0, cfg_hidden_init});
   endtask : rd_all

   task automatic pulse_low(input int which);
      @(posedge aclk);
      if (which == 0) system_reset_low <= 1'b0;
      if (which == 1) clock_ctrl_reset_low <= 1'b0;
      if (which == 2) power_on_reset_low <= 1'b0;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      if (which != 1) check({18'h0, periph_block_reset_low}, 34'h0);
      @(posedge aclk);
      {system_reset_low, clock_ctrl_reset_low, power_on_reset_low} <= 3'h7;
      repeat (2) @(posedge aclk);
   endtask : pulse_low

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {power_on_reset_low, system_reset_low, clock_ctrl_reset_low} = 3'h7;
      {hw_event, pc0, pc1, cfg_ext_ddr_unlock} = '0;
      cfg_bridge_field_unlock = 4'b0101;
      {cfg_soft_reset_init, cfg_soft_reset_unlock} = $random(seed);
      {cfg_ext_ddr_init, cfg_bridge_init} = {$random(seed), $random(seed)};
      {cfg_status_init, cfg_hidden_init} = {$random(seed), $random(seed)};
      hw_status = $random(seed);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      {e_soft, e_ddr, e_brg} = {cfg_soft_reset_init, cfg_ext_ddr_init,
         cfg_bridge_init};
      {e_plain, e_stk} = '0;
      rd_all();
      m = $random(seed);
      wr(swpb_pkg::OFF_SOFT_RESET, m, 4'hF, OK);
      e_soft = (e_soft & ~cfg_soft_reset_unlock)
         | (m[15:0] & cfg_soft_reset_unlock);
      m = $random(seed);
      wr(swpb_pkg::OFF_BRIDGE, m, 4'hF, OK);
      u = {{8{1'b0}}, {8{1'b1}}, {8{1'b0}}, {8{1'b1}}};
      e_brg = (e_brg & ~u) | (m & u);
      wr(swpb_pkg::OFF_EXT_DDR, $random(seed), 4'hF, OK);
      rd(swpb_pkg::OFF_EXT_DDR, e_ddr, OK);
      cfg_ext_ddr_unlock <= 1'b1;
      m = $random(seed);
      wr(swpb_pkg::OFF_EXT_DDR, m, 4'hF, OK);
      e_ddr = m;
      m = $random(seed);
      wr(swpb_pkg::OFF_PLAIN_RW, m, 4'b0010, OK);
      e_plain = m & 32'h0000_FF00;
      wr(swpb_pkg::OFF_HW_STATUS, m, 4'hF, OK);
      wr(swpb_pkg::OFF_HIDDEN, m, 4'hF, OK);
      wr(swpb_pkg::OFF_PRELOAD_STATUS, m, 4'hF, OK);
      wr(12'h004, m, 4'hF, swpb_pkg::RESP_SLVERR);
      @(posedge aclk);
      hw_event <= 8'hA5;
      @(posedge aclk);
      hw_event <= 8'h00;
      wr(swpb_pkg::OFF_STICKY, 32'h0000_0021, 4'h1, OK);
      e_stk = 8'h84;
      wr(swpb_pkg::OFF_CLEAR_PULSE, 32'h0000_0003, 4'h1, OK);
      wr(swpb_pkg::OFF_CLEAR_PULSE, 32'h0000_0002, 4'h1, OK);
      repeat (2) @(posedge aclk);
      check({2'h0, pc0}, 34'h1);
      check({2'h0, pc1}, 34'h2);
      rd_all();
      @(posedge aclk);
      cfg_soft_reset_init <= 16'($random(seed));
      cfg_ext_ddr_init <= 32'h0000_0000;
      {cfg_bridge_init, cfg_hidden_init} <= {$random(seed), $random(seed)};
      cfg_status_init <= $random(seed);
      pulse_low(0);
      e_soft = cfg_soft_reset_init;
      {e_plain, e_stk} = '0;
      rd_all();
      pulse_low(1);
      e_brg = cfg_bridge_init;
      rd_all();
      pulse_low(2);
      e_ddr = cfg_ext_ddr_init;
      rd_all();
      print_verdict();
   end
endmodule : tb_top

`default_nettype wire
